// ---- hw/pcc_core.sv ----
// Overview of operation
// - New preset accepted anytime, count untouched.
// - Up, preset below count: wrap, then complete.
// - Up, preset above count: complete on equality.
// - Down: always complete when count reaches zero.
// - Up, zero preset: no immediate completion, wrap first.
// - Hold-freeze: output held, further pulses ignored.
// - Hold-overcount: output held, counting continues past.
// - Pulse-overcount: one-second pulse, counting continues.
// - Pulse-recount: reload start value at completion.
// - Pulse-recount: pulses ignored during output pulse.
// - Fault: show code, output off, restore start preset.
// - Rate 30 Hz/5 kHz, taken at power-up only.
// - Config commit restarts count, output off.
`timescale 1ns/1ps
module pcc_core import pcc_pkg::*; #(
  parameter int PULSE_US_P = PULSE_US,
  parameter int FILT_SLOW_P = FILT_SLOW_US,
  parameter int FILT_FAST_P = FILT_FAST_US,
  parameter logic signed [CW-1:0] FULL_P = FULL_SCALE
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  // Count pin
  input wire logic count_pin,
  // Preset
  input wire logic [CW-1:0] preset_value,
  input wire logic preset_load,
  input wire logic [CW-1:0] preset_init,
  // Configuration
  input wire pcc_cfg_type cfg_in,
  input wire logic cfg_commit,
  input wire logic speed_strap_slow,
  // Fault
  input wire logic cpu_fault,
  // Status
  output logic signed [CW-1:0] count_value,
  output logic output_on,
  output logic complete,
  output logic fault_show,
  output logic [7:0] fault_code,
  output logic speed_slow
);
  logic any_rst;
  logic [5:0] div_r;
  logic us_tick;
  logic evt;
  pcc_cfg_type cfg_r;
  logic [CW-1:0] preset_r;
  logic [CW-1:0] startup_preset_r;
  logic signed [CW-1:0] count_r;
  logic signed [CW-1:0] start_val;
  logic signed [CW-1:0] step_val;
  logic done_r;
  logic count_en;
  logic hit;
  logic recount;
  pcc_out_type state_r;
  pcc_out_type state_nxt;
  logic [TW-1:0] pulse_r;

  assign any_rst = rst | por;
  assign recount = (cfg_r.mode == MODE_PULSE_RECOUNT);
  assign start_val = cfg_r.count_direction_down ? $signed(preset_r) : '0;
  assign count_value = count_r;
  assign fault_show = state_r[3];
  assign fault_code = CPU_FAULT_CODE;

  // Microsecond enable
  assign us_tick = (div_r == 6'(US_CYCLES - 1));
  always_ff @(posedge mclk) begin
    if (any_rst || us_tick) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  // Rate strap caught only at power-up
  always_ff @(posedge mclk) begin
    if (por) begin
      speed_slow <= speed_strap_slow;
    end
  end

  pcc_in_filter #(
    .SLOW_US(FILT_SLOW_P),
    .FAST_US(FILT_FAST_P)
  ) u_filter (
    .mclk(mclk),
    .rst(any_rst),
    .us_tick(us_tick),
    .slow_sel(speed_slow),
    .pin(count_pin),
    .rise(evt)
  );

  // Preset and start-up copy
  always_ff @(posedge mclk) begin
    if (por) begin
      preset_r <= preset_init;
      startup_preset_r <= preset_init;
    end else if (rst && state_r == OUT_FAULT) begin
      preset_r <= startup_preset_r;
    end else if (preset_load) begin
      preset_r <= preset_value;
    end
  end

  always_ff @(posedge mclk) begin
    if (por) begin
      cfg_r <= CFG_RESET;
    end else if (cfg_commit) begin
      cfg_r <= cfg_in;
    end
  end

  // Count step with wrap at full scale up, overcount to negative down
  always_comb begin
    step_val = count_r;
    if (cfg_r.count_direction_down) begin
      if (count_r != -FULL_P) begin
        step_val = count_r - 16'sh0001;
      end
    end else if (count_r >= FULL_P) begin
      step_val = '0;
    end else begin
      step_val = count_r + 16'sh0001;
    end
  end

  assign count_en = evt && state_r != OUT_FAULT
    && !(cfg_r.mode == MODE_HOLD_FREEZE && done_r)
    && !(recount && state_r == OUT_PULSE);
  assign hit = count_en && !done_r && (cfg_r.count_direction_down ?
    (step_val == '0) : (step_val == $signed(preset_r)));

  always_ff @(posedge mclk) begin
    if (any_rst) begin
      count_r <= '0;
      if (!por && cfg_r.count_direction_down) begin
        count_r <= (state_r == OUT_FAULT) ? $signed(startup_preset_r)
          : $signed(preset_r);
      end
      done_r <= 1'b0;
      complete <= 1'b0;
    end else if (cfg_commit) begin
      count_r <= cfg_in.count_direction_down ? $signed(preset_r) : '0;
      done_r <= 1'b0;
      complete <= 1'b0;
    end else begin
      complete <= hit;
      if (hit && recount) begin
        count_r <= start_val;
      end else if (count_en) begin
        count_r <= step_val;
      end
      if (hit && !recount) begin
        done_r <= 1'b1;
      end
    end
  end

  // Output sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OUT_OFF: begin
        if (hit) begin
          state_nxt = cfg_r.mode[1] ? OUT_PULSE : OUT_HOLD;
        end
      end
      OUT_HOLD: begin
        state_nxt = OUT_HOLD;
      end
      OUT_PULSE: begin
        if (us_tick && pulse_r == '0) begin
          state_nxt = OUT_OFF;
        end
      end
      OUT_FAULT: begin
        state_nxt = OUT_FAULT;
      end
      default: begin
        state_nxt = OUT_OFF;
      end
    endcase
    if (cpu_fault) begin
      state_nxt = OUT_FAULT;
    end
  end

  always_ff @(posedge mclk) begin
    if (any_rst || cfg_commit) begin
      state_r <= OUT_OFF;
      output_on <= 1'b0;
    end else begin
      state_r <= state_nxt;
      output_on <= (state_nxt == OUT_HOLD) || (state_nxt == OUT_PULSE);
    end
  end

  always_ff @(posedge mclk) begin
    if (any_rst || state_r != OUT_PULSE) begin
      pulse_r <= TW'(PULSE_US_P - 1);
    end else if (us_tick && pulse_r != '0) begin
      pulse_r <= pulse_r - TW'(1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (any_rst);

  preset_take_a: assert property (preset_load && !cfg_commit && state_r != OUT_FAULT
    |=> preset_r == $past(preset_value) && (complete || $stable(count_r) || $past(evt)))
    else $error("preset not taken");
  up_wrap_a: assert property (!cfg_r.count_direction_down && count_r == FULL_P && count_en
    && !cfg_commit && !recount |=> count_r == '0)
    else $error("up count did not wrap");
  up_hit_a: assert property (complete && !cfg_r.count_direction_down && !recount
    |-> count_r == $signed(preset_r))
    else $error("up completion off preset");
  down_hit_a: assert property (complete && cfg_r.count_direction_down && !recount
    |-> count_r == '0)
    else $error("down completion not at zero");
  zero_preset_a: assert property (complete && !cfg_r.count_direction_down && preset_r == '0
    |-> $past(count_r) == FULL_P)
    else $error("zero preset completed early");
  freeze_hold_a: assert property (cfg_r.mode == MODE_HOLD_FREEZE && done_r && !cfg_commit
    |=> $stable(count_r))
    else $error("frozen count moved");
  hold_out_a: assert property (state_r == OUT_HOLD && !cfg_commit && !cpu_fault
    |=> output_on)
    else $error("held output dropped");
  pulse_end_a: assert property (state_r == OUT_PULSE && pulse_r == '0 && us_tick
    && !cfg_commit && !cpu_fault |=> !output_on ##1 !output_on)
    else $error("pulse did not end");
  recount_load_a: assert property (complete && recount |-> count_r == start_val)
    else $error("recount did not reload");
  recount_block_a: assert property (state_r == OUT_PULSE && recount && !cfg_commit
    |=> $stable(count_r))
    else $error("counted during pulse");
  fault_off_a: assert property (cpu_fault && !cfg_commit |=> !output_on && fault_show)
    else $error("fault did not force off");
  rate_keep_a: assert property (!por |=> $stable(speed_slow))
    else $error("rate changed without power-up");
  commit_restart_a: assert property (cfg_commit |=> !output_on
    && count_r == (cfg_r.count_direction_down ? $signed(preset_r) : 16'sh0000))
    else $error("commit did not restart");
  // Front reset itself is the antecedent, so only power-up may disable it
  reset_load_a: assert property (@(posedge mclk) disable iff (por)
    rst && !preset_load && !cfg_commit && state_r != OUT_FAULT
    |=> !output_on && count_r == start_val)
    else $error("reset did not reload");

  hold_seen_c: cover property (state_r == OUT_HOLD && count_r != start_val);
  pulse_seen_c: cover property (state_r == OUT_PULSE ##1 state_r == OUT_OFF);
  recount_seen_c: cover property (complete && recount);
  fault_seen_c: cover property (state_r == OUT_FAULT);
endmodule : pcc_core

// ---- hw/pcc_pkg.sv ----
package pcc_pkg;
  // Count datapath
  localparam int CW = 16;
  localparam logic signed [CW-1:0] FULL_SCALE = 16'sh270F;
  // Clock and timing
  localparam int MCLK_HZ = 40_000_000;
  localparam int US_CYCLES = MCLK_HZ / 1_000_000;
  localparam int PULSE_MS = 1000;
  localparam int PULSE_US = PULSE_MS * 1000;
  localparam int RATE_SLOW_HZ = 30;
  localparam int RATE_FAST_HZ = 5000;
  // Debounce: a quarter of the shortest input period, rounded down
  localparam int FILT_SLOW_US = 1_000_000 / (4 * RATE_SLOW_HZ);
  localparam int FILT_FAST_US = 1_000_000 / (4 * RATE_FAST_HZ);
  localparam int TW = 24;
  // Fault display code
  localparam logic [7:0] CPU_FAULT_CODE = 8'h00;

  typedef enum logic [1:0] {
    MODE_HOLD_FREEZE = 2'h0,
    MODE_HOLD_OVER = 2'h1,
    MODE_PULSE_OVER = 2'h2,
    MODE_PULSE_RECOUNT = 2'h3
  } pcc_mode_type;

  typedef struct packed {
    logic count_direction_down;
    pcc_mode_type mode;
  } pcc_cfg_type;

  localparam pcc_cfg_type CFG_RESET = 3'h0;

  typedef enum logic [3:0] {
    OUT_OFF = 4'h1,
    OUT_HOLD = 4'h2,
    OUT_PULSE = 4'h4,
    OUT_FAULT = 4'h8
  } pcc_out_type;
endpackage : pcc_pkg

// ---- hw/pcc_in_filter.sv ----
`timescale 1ns/1ps
module pcc_in_filter import pcc_pkg::*; #(
  parameter int SLOW_US = FILT_SLOW_US,
  parameter int FAST_US = FILT_FAST_US
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Timing
  input wire logic us_tick,
  input wire logic slow_sel,
  // Pin and event
  input wire logic pin,
  output logic rise
);
  logic [2:0] sync_r;
  logic level_r;
  logic [TW-1:0] stab_r;
  logic [TW-1:0] limit;

  assign limit = slow_sel ? TW'(SLOW_US) : TW'(FAST_US);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], pin};
    end
  end

  // Level must stay changed for the debounce time before it counts
  always_ff @(posedge mclk) begin
    if (rst) begin
      level_r <= 1'b0;
      stab_r <= '0;
      rise <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (sync_r[1] != sync_r[2] || sync_r[2] == level_r) begin
        stab_r <= '0;
      end else if (us_tick) begin
        if (stab_r >= limit) begin
          level_r <= sync_r[2];
          rise <= sync_r[2];
          stab_r <= '0;
        end else begin
          stab_r <= stab_r + TW'(1);
        end
      end
    end
  end
endmodule : pcc_in_filter

// ---- dv/pcc_pulse_src.sv ----
`timescale 1ns/1ps
module pcc_pulse_src #(
  parameter int HALF = 300
) (
  // Clock
  input wire logic mclk,
  // Request
  input wire logic go,
  // Pin side
  output logic pin,
  output logic idle
);
  int cnt;
  initial begin
    pin = 1'b0;
    idle = 1'b1;
    cnt = 0;
  end
  // One clean pulse per request, slow enough for a contact source
  always @(negedge mclk) begin
    if (idle && go) begin
      idle <= 1'b0;
      pin <= 1'b1;
      cnt <= 0;
    end else if (!idle) begin
      cnt <= cnt + 1;
      if (cnt == HALF - 1) pin <= 1'b0;
      if (cnt == 2 * HALF - 1) idle <= 1'b1;
    end
  end
endmodule : pcc_pulse_src

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t %s", $time, m); end end
module tb_top import pcc_pkg::*; ;
  typedef struct {
    pcc_cfg_type cfg;
    logic [CW-1:0] pre;
    int n;
    logic signed [CW-1:0] cnt;
    logic on;
    logic done;
  } pcc_row_type;
  logic mclk, rst, por, go, preset_load, cfg_commit, speed_strap_slow, cpu_fault, seen, seen_clr;
  logic [CW-1:0] preset_value, preset_init;
  pcc_cfg_type cfg_in;
  logic count_pin, idle, output_on, complete, fault_show, speed_slow;
  logic signed [CW-1:0] count_value;
  logic [7:0] fault_code;
  int fail_count, check_count;
  pcc_row_type rows [7];
  pcc_core #(.PULSE_US_P(40), .FILT_SLOW_P(3), .FILT_FAST_P(1), .FULL_P(16'sh000F)) i_pcc_core (
    .mclk(mclk), .rst(rst), .por(por), .count_pin(count_pin), .preset_value(preset_value),
    .preset_load(preset_load), .preset_init(preset_init), .cfg_in(cfg_in),
    .cfg_commit(cfg_commit), .speed_strap_slow(speed_strap_slow), .cpu_fault(cpu_fault),
    .count_value(count_value), .output_on(output_on), .complete(complete),
    .fault_show(fault_show), .fault_code(fault_code), .speed_slow(speed_slow));
  pcc_pulse_src i_pcc_pulse_src (.mclk(mclk), .go(go), .pin(count_pin), .idle(idle));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) seen <= !seen_clr && (seen || complete === 1'b1);
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task pulses(input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      go <= 1'b1;
      @(negedge mclk);
      go <= 1'b0;
      w = 0;
      do begin
        @(negedge mclk);
        w++;
      end while (!idle && w < 2000);
    end
  endtask : pulses
  task load(input logic [CW-1:0] v);
    preset_value <= v;
    preset_load <= 1'b1;
    @(negedge mclk);
    preset_load <= 1'b0;
    @(negedge mclk);
  endtask : load
  task commit(input pcc_cfg_type c);
    cfg_in <= c;
    cfg_commit <= 1'b1;
    @(negedge mclk);
    cfg_commit <= 1'b0;
    @(negedge mclk);
  endtask : commit
  task reset_pulse;
    rst <= 1'b1;
    seen_clr <= 1'b1;
    repeat (2) @(negedge mclk);
    rst <= 1'b0;
    seen_clr <= 1'b0;
    @(negedge mclk);
  endtask : reset_pulse
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    rows[0] = '{'{1'b0, MODE_HOLD_FREEZE}, 16'h0003, 5, 16'sh0003, 1'b1, 1'b1};
    rows[1] = '{'{1'b0, MODE_HOLD_OVER}, 16'h0003, 5, 16'sh0005, 1'b1, 1'b1};
    rows[2] = '{'{1'b1, MODE_HOLD_OVER}, 16'h0003, 5, 16'shFFFE, 1'b1, 1'b1};
    rows[3] = '{'{1'b0, MODE_PULSE_OVER}, 16'h0002, 3, 16'sh0003, 1'b0, 1'b1};
    rows[4] = '{'{1'b1, MODE_PULSE_RECOUNT}, 16'h0002, 2, 16'sh0002, 1'b0, 1'b1};
    rows[5] = '{'{1'b0, MODE_HOLD_FREEZE}, 16'h0000, 16, 16'sh0000, 1'b1, 1'b1};
    rows[6] = '{'{1'b1, MODE_HOLD_FREEZE}, 16'h0003, 2, 16'sh0001, 1'b0, 1'b0};
    {rst, por, go, preset_load, cfg_commit, cpu_fault, seen_clr} = 7'h61;
    speed_strap_slow = 1'b1;
    preset_value = 16'h0000;
    preset_init = 16'h0005;
    cfg_in = CFG_RESET;
    fail_count = 0;
    check_count = 0;
    repeat (2) @(negedge mclk);
    {rst, por, seen_clr} = 3'h0;
    @(negedge mclk);
    `CHK(count_value, 16'sh0000, "count after power-up")
    `CHK(speed_slow, 1'b1, "rate strap not taken")
    speed_strap_slow <= 1'b0;
    for (int r = 0; r < 7; r++) begin
      reset_pulse();
      load(rows[r].pre);
      commit(rows[r].cfg);
      pulses(rows[r].n);
      repeat (1800) @(negedge mclk);
      `CHK(count_value, rows[r].cnt, "row count")
      `CHK(output_on, rows[r].on, "row output")
      `CHK(seen, rows[r].done, "row completion")
      $display("row %0d done", r);
    end
    $display("mode table done");
    reset_pulse();
    load(16'h000A);
    commit('{1'b0, MODE_HOLD_OVER});
    pulses(5);
    load(16'h0003);
    `CHK(count_value, 16'sh0005, "preset load moved count")
    pulses(13);
    `CHK(seen, 1'b0, "early completion")
    pulses(1);
    `CHK(count_value, 16'sh0003, "wrap completion count")
    `CHK(seen, 1'b1, "no completion after wrap")
    reset_pulse();
    pulses(2);
    load(16'h0004);
    pulses(1);
    `CHK(seen, 1'b0, "early completion")
    pulses(1);
    `CHK(seen, 1'b1, "no completion at new preset")
    $display("preset change done");
    reset_pulse();
    load(16'h0002);
    commit('{1'b0, MODE_PULSE_RECOUNT});
    pulses(2);
    `CHK(count_value, 16'sh0000, "no reload")
    pulses(1);
    `CHK(count_value, 16'sh0000, "counted during pulse")
    repeat (1800) @(negedge mclk);
    `CHK(output_on, 1'b0, "pulse too long")
    pulses(2);
    `CHK(output_on, 1'b1, "second completion missing")
    commit('{1'b1, MODE_HOLD_FREEZE});
    `CHK(count_value, 16'sh0002, "commit restart")
    `CHK(output_on, 1'b0, "commit output")
    $display("recount and commit done");
    load(16'h0009);
    cpu_fault <= 1'b1;
    @(negedge mclk);
    cpu_fault <= 1'b0;
    pulses(1);
    `CHK(fault_show, 1'b1, "fault not shown")
    `CHK(fault_code, CPU_FAULT_CODE, "fault code")
    `CHK(count_value, 16'sh0002, "counted in fault")
    reset_pulse();
    `CHK(count_value, 16'sh0005, "start-up preset lost")
    `CHK(fault_show, 1'b0, "fault kept")
    `CHK(speed_slow, 1'b1, "rate changed without power-up")
    $display("fault done");
    por <= 1'b1;
    repeat (2) @(negedge mclk);
    por <= 1'b0;
    @(negedge mclk);
    `CHK(speed_slow, 1'b0, "rate strap not retaken")
    `CHK(count_value, 16'sh0000, "count after power restart")
    pulses(1);
    `CHK(count_value, 16'sh0001, "fast filter count")
    $display("power restart done");
    complete_run();
  end
endmodule : tb_top
